// ==== rtl/pointer_quadrature_map.svh ====
`ifndef POINTER_QUADRATURE_MAP_SVH
`define POINTER_QUADRATURE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PQ_LEFT_COUNTS_OFS 12'ha00
`define PQ_RIGHT_COUNTS_OFS 12'h00c
`define PQ_PRELOAD_OFS 12'h036

// ----------------------------------------------------------------
// field positions inside a counter word
// ----------------------------------------------------------------
`define PQ_VERT_MSB 15
`define PQ_VERT_LSB 8
`define PQ_HORIZ_MSB 7
`define PQ_HORIZ_LSB 0
`define PQ_PRELOAD_VERT_LSB 10
`define PQ_PRELOAD_HORIZ_LSB 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PQ_COUNT_RESET 8'h00
`define PQ_WORD_RESET 16'h0000

`endif

// ==== rtl/pointer_quadrature_pkg.sv ====
package pointer_quadrature_pkg;

    // one 8-bit motion counter
    typedef logic [7:0] count_t;

    // counter slots: left pair first, vertical before horizontal
    typedef enum logic [1:0] {
        AXIS_LEFT_VERT = 2'h0,
        AXIS_LEFT_HORIZ = 2'h1,
        AXIS_RIGHT_VERT = 2'h2,
        AXIS_RIGHT_HORIZ = 2'h3
    } axis_e;

endpackage

// ==== rtl/pointer_quadrature_counters.sv ====
`timescale 1ns/10ps
`include "pointer_quadrature_map.svh"

// Notes on behaviour
// (RQ1) two read-only words, left then right pair
// (RQ2) vertical in high byte, horizontal in low
// (RQ3) pin sampled on clock and inverted phase
// (RQ4) quadrature step counts up or down
// (RQ5) counter bits 1:0 follow sampled inputs
// (RQ6) stick left/right active high on bit 1
// (RQ7) software xors bit pairs for forward/back
// (RQ8) stick pulls connector pin low when active
// (RQ9) test write loads all four counters together
// (RQ10) test write loads bits 7:2 only
// (RQ11) counters wrap; reading changes nothing
// (RQ12) samples synchronised before direction decoding
module pointer_quadrature_counters #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic port0_vertical_input,
    input wire logic port0_horizontal_input,
    input wire logic port1_vertical_input,
    input wire logic port1_horizontal_input,
    input wire logic colour_cycle_clock,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (ADDR_WIDTH != 12) begin : g_bad_width
        $error("address width must be 12");
    end

    // ----------------------------------------------------------------
    // next value of one counter from its sampled pair
    // ----------------------------------------------------------------
    function automatic pointer_quadrature_pkg::count_t next_count(
        input pointer_quadrature_pkg::count_t cnt,
        input logic a,
        input logic b
    );
        logic [1:0] low;
        logic [5:0] high;
        low = {b, a ^ b}; // bit 1 is the stick left/right sample [RQ6]
        high = cnt[7:2];
        if (cnt[1:0] == 2'h3 && low == 2'h0) begin
            high = high + 6'h01; // up step past three, wraps
        end else if (cnt[1:0] == 2'h0 && low == 2'h3) begin
            high = high - 6'h01; // down step below zero, wraps
        end
        return {high, low};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [4:0] pin_raw;
    logic colour_prev_q;
    logic [3:0] phase_a_q;
    logic [3:0] phase_b_q;
    logic [3:0] phase_a_d;
    logic [3:0] phase_b_d;
    logic [3:0] pins_high;
    logic colour_up;
    logic colour_down;

    // bit 4 is the colour cycle clock, 0..3 follow the counter slots
    assign pin_raw = {colour_cycle_clock, port1_horizontal_input, port1_vertical_input,
                      port0_horizontal_input, port0_vertical_input};

    // two flops on every pin before use [RQ12]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // phase sampling
    // ----------------------------------------------------------------
    // connector levels are active low, stored inverted [RQ8]
    assign pins_high = ~pin_sync_q[3:0];
    assign colour_up = pin_sync_q[4] & ~colour_prev_q;
    assign colour_down = ~pin_sync_q[4] & colour_prev_q;

    // phase a on clock high, phase b on its inverted phase [RQ3]
    always_comb begin
        phase_a_d = phase_a_q;
        phase_b_d = phase_b_q;
        if (colour_up) begin
            phase_a_d = pins_high;
        end
        if (colour_down) begin
            phase_b_d = pins_high;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            colour_prev_q <= 1'b0;
            phase_a_q <= 4'h0;
            phase_b_q <= 4'h0;
        end else begin
            colour_prev_q <= pin_sync_q[4];
            phase_a_q <= phase_a_d;
            phase_b_q <= phase_b_d;
        end
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    pointer_quadrature_pkg::count_t count_q [4];
    pointer_quadrature_pkg::count_t count_d [4];
    logic preload_hit;
    logic left_hit;
    logic right_hit;

    assign preload_hit = reg_wr && reg_addr == `PQ_PRELOAD_OFS;
    assign left_hit = reg_rd && reg_addr == `PQ_LEFT_COUNTS_OFS;
    assign right_hit = reg_rd && reg_addr == `PQ_RIGHT_COUNTS_OFS;

    // quadrature decode, low bits track inputs, preload upper six
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            count_d[i] = next_count(count_q[i], phase_a_q[i], phase_b_q[i]); // [RQ4] [RQ5] [RQ11]
            if (preload_hit) begin // [RQ9]
                if (i == 0 || i == 2) begin
                    count_d[i][7:2] = data_in[15:10]; // [RQ10]
                end else begin
                    count_d[i][7:2] = data_in[7:2]; // [RQ10]
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                count_q[i] <= `PQ_COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                count_q[i] <= count_d[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [15:0] data_d;
    logic oe_n_d;

    // read returns the pair without touching the counters [RQ1] [RQ2] [RQ11]
    always_comb begin
        data_d = data_out;
        oe_n_d = 1'b1;
        if (left_hit) begin
            data_d = {count_q[0], count_q[1]};
            oe_n_d = 1'b0;
        end else if (right_hit) begin
            data_d = {count_q[2], count_q[3]};
            oe_n_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `PQ_WORD_RESET;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= data_d;
            data_oe_n <= oe_n_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_left_read;
        left_hit;
    endsequence

    sequence s_driven_once;
        !data_oe_n ##1 (data_oe_n || $past(reg_rd));
    endsequence

    a_left_word: assert property (s_left_read |=> data_out == {$past(count_q[0]), // [RQ1]
        $past(count_q[1])}) else $error("left word wrong");
    a_right_word: assert property (right_hit |=> data_out[15:8] == $past(count_q[2]) // [RQ2]
        && data_out[7:0] == $past(count_q[3])) else $error("right word wrong");
    a_read_drive: assert property (s_left_read |=> s_driven_once) // [RQ1]
        else $error("read drive wrong");
    a_preload_vert: assert property (preload_hit |=> count_q[0][7:2] == $past(data_in[15:10]) // [RQ9]
        && count_q[2][7:2] == $past(data_in[15:10])) else $error("vertical preload wrong");
    a_preload_horiz: assert property (preload_hit |=> count_q[1][7:2] == $past(data_in[7:2]) // [RQ10]
        && count_q[3][7:2] == $past(data_in[7:2])) else $error("horizontal preload wrong");
    a_low_follow: assert property (##1 count_q[1][1:0] == {$past(phase_b_q[1]), // [RQ5]
        $past(phase_a_q[1] ^ phase_b_q[1])}) else $error("low bits not following");
    a_stick_bit: assert property (##1 count_q[2][1] == $past(phase_b_q[2])) // [RQ6]
        else $error("stick bit wrong");
    a_phase_sample: assert property (colour_up |=> phase_a_q == ~$past(pin_sync_q[3:0])) // [RQ3]
        else $error("phase a not sampled");
    a_up_carry: assert property (!preload_hit && count_q[0][1:0] == 2'h3 && // [RQ4]
        phase_a_q[0] == 1'b0 && phase_b_q[0] == 1'b0
        |=> count_q[0][7:2] == $past(count_q[0][7:2]) + 6'h01) else $error("no carry");
    a_read_keeps: assert property (reg_rd && !preload_hit && phase_a_q == $past(phase_a_q) // [RQ11]
        && phase_b_q == $past(phase_b_q) && count_q[3][1:0] == {phase_b_q[3],
        phase_a_q[3] ^ phase_b_q[3]} |=> $stable(count_q[3])) else $error("read changed count");

endmodule // pointer_quadrature_counters

// ==== verification/pointer_stick_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// two controllers sharing one pin per axis
// ----------------------------------------------------------------
module pointer_stick_model (
    input wire logic colour_cycle_clock,
    input wire logic [7:0] phase,
    output logic [3:0] pin
);
    // axis k takes phase[2k+1:2k]; a shown while clock high, b while low
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pin[k] = colour_cycle_clock ? ~(phase[2*k+1] ^ phase[2*k]) : ~phase[2*k+1];
        end
    end
endmodule // pointer_stick_model

// ==== verification/pointer_quadrature_counters_tb.sv ====
`timescale 1ns/10ps
`include "pointer_quadrature_map.svh"

module pointer_quadrature_counters_tb;
    logic core_clk, rst_n, colour_clk, reg_rd, reg_wr, data_oe_n;
    logic [11:0] reg_addr;
    logic [15:0] data_in, data_out, got;
    logic [7:0] phase, v;
    logic [3:0] pin;
    int n_mismatch, compares;

    pointer_stick_model partner (.colour_cycle_clock(colour_clk), .phase(phase), .pin(pin));

    pointer_quadrature_counters dut (.core_clk(core_clk), .rst_n(rst_n),
        .port0_vertical_input(pin[0]), .port0_horizontal_input(pin[1]),
        .port1_vertical_input(pin[2]), .port1_horizontal_input(pin[3]),
        .colour_cycle_clock(colour_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

    // ----------------------------------------------------------------
    // clocks and hang guard
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // colour clock: 8 core cycles per half period
    initial begin
        colour_clk = 1'b0;
        forever #80 colour_clk = ~colour_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // read strobe one cycle, answer sampled in the following cycle
    task automatic rd(input logic [11:0] a, input logic oe_n_exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        got = data_out;
        chk({15'h0000, data_oe_n}, {15'h0000, oe_n_exp});
        reg_rd = 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        data_in = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    // hold pins across several colour clock periods
    task automatic settle();
        repeat (48) @(negedge core_clk);
    endtask
    task automatic test_done();
        $display("n_mismatch %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 12'h000;
        data_in = 16'h0000;
        phase = 8'h00;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        settle();
        rd(`PQ_LEFT_COUNTS_OFS, 1'b0);
        chk(got, 16'h0000);
        rd(`PQ_PRELOAD_OFS, 1'b1);
        rd(12'h0a0, 1'b1);
        // one step on left vertical, then preload keeps low bits
        phase = 8'h01;
        settle();
        wr(`PQ_PRELOAD_OFS, 16'hfc5a);
        rd(`PQ_LEFT_COUNTS_OFS, 1'b0);
        chk(got, 16'hfd58);
        chk({15'h0000, got[9] ^ got[8]}, 16'h0001);
        rd(`PQ_LEFT_COUNTS_OFS, 1'b0);
        chk(got, 16'hfd58);
        rd(`PQ_RIGHT_COUNTS_OFS, 1'b0);
        chk(got, 16'hfc58);
        // left vertical counts up through the wrap
        for (int i = 2; i <= 4; i++) begin
            phase[1:0] = 2'(i);
            settle();
            v = 8'hfc + 8'(i);
            rd(`PQ_LEFT_COUNTS_OFS, 1'b0);
            chk(got, {v, 8'h58});
        end
        // right horizontal counts down, low bits follow the stick
        for (int i = 1; i <= 4; i++) begin
            phase[7:6] = 2'(4 - i);
            settle();
            v = 8'h58 - 8'(i);
            rd(`PQ_RIGHT_COUNTS_OFS, 1'b0);
            chk(got, {8'hfc, v});
        end
        // right vertical jumps two steps: low bits move, no count
        // change while the colour clock is low, so phase a is sampled first
        @(posedge core_clk);
        for (int t = 0; t < 20 && colour_clk; t++) begin
            @(posedge core_clk);
        end
        if (colour_clk) begin
            n_mismatch++;
            $display("MISMATCH at %0t: colour clock stuck high", $time);
        end
        @(negedge core_clk);
        phase[5:4] = 2'h2;
        settle();
        rd(`PQ_RIGHT_COUNTS_OFS, 1'b0);
        chk(got, 16'hfe54);
        test_done();
    end
endmodule // pointer_quadrature_counters_tb
